// >>> verilog/rqc_receive_queue_command.sv
// receive queue command register bank with axi4-lite slave
// How it works
// - bit 12 reports duration threshold cause
// - bit 11 reports byte count cause
// - bit 10 reports frame count cause
// - status bits refresh on interrupt acknowledge
// - bit 9 enables two byte header offset
// - bit 7 enables duration threshold interrupt
// - bit 6 enables byte count interrupt
// - bit 5 enables frame count interrupt
// - bit 4 enables automatic frame dequeue
// - open window blocks other registers
// - release bit self clears when freed
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "rqc_defines.svh"
module rqc_receive_queue_command #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // threshold conditions from the receive queue
  input  wire logic              duration_exceeded,
  input  wire logic              byte_count_exceeded,
  input  wire logic              frame_count_exceeded,
  // frame release handshake with the queue memory
  output logic                   release_req,
  input  wire logic              release_done,
  // controls to the receive and transmit datapath
  output logic                   header_align_offset_en,
  output logic                   auto_dequeue_en,
  output logic                   dma_window_open,
  output logic                   rx_irq_req,
  // interrupt
  output logic                   irq
);

  // registers
  rqc_pkg::rqc_word_t    cmd_q;
  rqc_pkg::rqc_word_t    cmd_d;
  rqc_pkg::rqc_rel_e     rel_q;
  rqc_pkg::rqc_rel_e     rel_d;
  logic [2:0]            hit_q;
  logic [2:0]            hit_d;
  logic                  dma_q;
  logic                  rx_irq_pend_q;
  logic [2:0]            stat_q;
  logic [2:0]            stat_d;
  logic [2:0]            mask_q;
  logic [ADDR_W-1:0]     awaddr_q;
  logic                  aw_held_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  w_held_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  rvalid_q;
  logic [31:0]           rdata_q;
  logic [1:0]            rresp_q;

  // write channel capture: address and data may come in either order
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs  = s_axi_wvalid && s_axi_wready;
  wire [ADDR_W-1:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0]       wr_data = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0]        wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
  wire aw_have = aw_held_q || aw_hs;
  wire w_have  = w_held_q || w_hs;
  wire wr_go   = aw_have && w_have && !bvalid_q;

  // one-hot register select, shared by the write and read decoders
  function automatic logic [4:0] map_sel(input logic [ADDR_W-1:0] addr);
    map_sel = {addr == ADDR_W'(`RQC_THR_ADDR),
               addr == ADDR_W'(`RQC_ISR_ADDR),
               addr == ADDR_W'(`RQC_STAT_ADDR),
               addr == ADDR_W'(`RQC_MASK_ADDR),
               addr == ADDR_W'(`RQC_CMD_ADDR)};
  endfunction

  // refusal code shared by both response channels
  function automatic logic [1:0] resp_code(input logic mapped,
                                           input logic blocked);
    if (!mapped) begin
      resp_code = `RQC_RESP_DECERR;
    end else if (blocked) begin
      resp_code = `RQC_RESP_SLVERR;
    end else begin
      resp_code = `RQC_RESP_OKAY;
    end
  endfunction

  // address decode; while the dma window is open only the command word answers
  wire [4:0] wsel = map_sel(wr_addr);
  wire wsel_cmd  = wsel[0];
  wire wsel_mask = wsel[1];
  wire wsel_stat = wsel[2];
  wire wsel_isr  = wsel[3];
  wire wmapped   = |wsel;
  wire wblocked  = dma_q && wmapped && !wsel_cmd;
  wire wr_ok     = wr_go && wmapped && !wblocked;
  wire wr_cmd    = wr_ok && wsel_cmd;
  wire wr_lo     = wr_strb[0];
  wire wr_hi     = wr_strb[1];
  wire dma_wr    = wr_cmd && wr_lo;
  wire mask_wr   = wr_ok && wsel_mask && wr_lo;
  wire stat_wr   = wr_ok && wsel_stat && wr_lo;

  // acknowledge of the receive interrupt, one written to bit 13 of the isr word
  wire rx_ack = wr_ok && wsel_isr && wr_hi && wr_data[`RQC_BIT_RX_IRQ];

  // enabled threshold conditions
  wire [2:0] cond_raw = {duration_exceeded, byte_count_exceeded, frame_count_exceeded};
  wire [2:0] cond_en  = {cmd_q[`RQC_BIT_DUR_EN], cmd_q[`RQC_BIT_BYTE_EN], cmd_q[`RQC_BIT_FRM_EN]};
  wire [2:0] cond_on  = cond_raw & cond_en;
  assign rx_irq_req = |cond_on;

  // cause bits are a snapshot taken at acknowledge, so they stay stable while software reads them
  assign hit_d = rx_ack ? cond_on : hit_q;

  // command word next value; read-only and write-only bits are not stored here
  function automatic rqc_pkg::rqc_word_t merge16(input rqc_pkg::rqc_word_t old_v,
                                                 input logic [15:0] new_v,
                                                 input logic lo,
                                                 input logic hi);
    merge16 = {hi ? new_v[15:8] : old_v[15:8], lo ? new_v[7:0] : old_v[7:0]};
  endfunction

  wire rqc_pkg::rqc_word_t cmd_wr = merge16(cmd_q, wr_data[15:0], wr_lo, wr_hi) & `RQC_CMD_RW_MASK;
  // a second release while one is in flight is dropped
  wire rel_start = wr_cmd && wr_lo && wr_data[`RQC_BIT_REL] && (rel_q == rqc_pkg::RQC_REL_IDLE);

  always_comb begin
    cmd_d = cmd_q;
    if (wr_cmd) begin
      cmd_d = {cmd_wr[15:1], cmd_q[`RQC_BIT_REL]};
    end
  end

  // release sequencer: request held until the memory reports it free
  always_comb begin
    rel_d = rel_q;
    unique case (rel_q)
      rqc_pkg::RQC_REL_IDLE: begin
        if (rel_start) begin
          rel_d = rqc_pkg::RQC_REL_BUSY;
        end
      end
      rqc_pkg::RQC_REL_BUSY: begin
        if (release_done) begin
          rel_d = rqc_pkg::RQC_REL_IDLE;
        end
      end
      default: rel_d = rqc_pkg::RQC_REL_IDLE;
    endcase
  end
  wire rel_busy = rel_q == rqc_pkg::RQC_REL_BUSY;
  assign release_req = rel_busy;

  // outputs to the datapath
  assign header_align_offset_en = cmd_q[`RQC_BIT_ALIGN];
  assign auto_dequeue_en        = cmd_q[`RQC_BIT_DEQ_EN];
  assign dma_window_open        = dma_q;

  // sticky events; a set in the clearing cycle wins
  wire rel_fin  = rel_busy && release_done;
  // rising edge only, so a standing condition logs one event
  wire irq_rise = rx_irq_req && !rx_irq_pend_q;
  wire ev_blocked = wr_go && wblocked;
  wire [2:0] ev   = {ev_blocked, irq_rise, rel_fin};
  wire [2:0] stat_clr = stat_wr ? wr_data[2:0] : 3'h0;
  assign stat_d = (stat_q & ~stat_clr) | ev;
  // level output, stays high until software clears the event
  assign irq    = |(stat_q & mask_q);

  // read decode
  wire [4:0] rsel = map_sel(s_axi_araddr);
  wire rsel_cmd  = rsel[0];
  wire rsel_mask = rsel[1];
  wire rsel_stat = rsel[2];
  wire rsel_isr  = rsel[3];
  wire rsel_thr  = rsel[4];
  wire rmapped   = |rsel;
  wire rblocked  = dma_q && rmapped && !rsel_cmd;
  wire [15:0] cmd_view = {cmd_q[15:13], hit_q, cmd_q[9:4], 1'b0, cmd_q[2:1], rel_busy};
  wire [31:0] cmd_word  = {16'h0000, cmd_view};
  wire [31:0] stat_word = {29'h0, stat_q};
  wire [31:0] mask_word = {29'h0, mask_q};
  wire [31:0] thr_word  = {29'h0, cond_raw};
  wire [31:0] isr_word  = {18'h0, rx_irq_req, 13'h0};
  wire [31:0] rd_val = rblocked  ? 32'h0000_0000 :
                       rsel_cmd  ? cmd_word :
                       rsel_stat ? stat_word :
                       rsel_mask ? mask_word :
                       rsel_thr  ? thr_word :
                       rsel_isr  ? isr_word :
                                   32'h0000_0000;
  wire [1:0] rd_resp = resp_code(rmapped, rblocked);
  // one read in flight; the next address waits until rready takes the data
  assign s_axi_arready = !rvalid_q;
  wire ar_hs = s_axi_arvalid && s_axi_arready;

  wire [1:0] wr_resp = resp_code(wmapped, wblocked);

  // responses straight from their registers
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // command word and release sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_q <= `RQC_CMD_RESET;
      rel_q <= rqc_pkg::RQC_REL_IDLE;
    end else begin
      cmd_q <= cmd_d;
      rel_q <= rel_d;
    end
  end

  // cause snapshot and interrupt request history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_q         <= 3'h0;
      rx_irq_pend_q <= 1'b0;
    end else begin
      hit_q         <= hit_d;
      rx_irq_pend_q <= rx_irq_req;
    end
  end

  // event status and mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= 3'h0;
      mask_q <= 3'h0;
    end else begin
      stat_q <= stat_d;
      if (mask_wr) begin
        mask_q <= wr_data[2:0];
      end
    end
  end

  // dma window, written by any command write carrying the low byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dma_q <= 1'b0;
    end else if (dma_wr) begin
      dma_q <= wr_data[`RQC_BIT_DMA];
    end
  end

  // write address holding, for data that arrives later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end else if (aw_hs) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end
  end

  // write data holding, for an address that arrives later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end else if (w_hs) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end
  end

  // write response, raised once both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RQC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_resp;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read valid, held until the master takes the beat
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // read payload, captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RQC_RESP_OKAY;
    end else if (ar_hs) begin
      rdata_q <= rd_val;
      rresp_q <= rd_resp;
    end
  end

endmodule

// >>> verilog/rqc_defines.svh
// register offsets, bit positions and reset values of the receive queue command block
`ifndef RQC_DEFINES_SVH
`define RQC_DEFINES_SVH
`define RQC_CMD_IDX          8'h82
`define RQC_CMD_ADDR         12'h208
`define RQC_STAT_ADDR        12'h300
`define RQC_MASK_ADDR        12'h304
`define RQC_THR_ADDR         12'h308
`define RQC_ISR_ADDR         12'h30c
`define RQC_BIT_DUR_HIT      12
`define RQC_BIT_BYTE_HIT     11
`define RQC_BIT_FRM_HIT      10
`define RQC_BIT_ALIGN        9
`define RQC_BIT_DUR_EN       7
`define RQC_BIT_BYTE_EN      6
`define RQC_BIT_FRM_EN       5
`define RQC_BIT_DEQ_EN       4
`define RQC_BIT_DMA          3
`define RQC_BIT_REL          0
`define RQC_BIT_RX_IRQ       13
`define RQC_CMD_RESET        16'h0000
`define RQC_CMD_RW_MASK      16'he2f1
`define RQC_EV_RELEASED      0
`define RQC_EV_RX_IRQ        1
`define RQC_EV_BLOCKED       2
`define RQC_RESP_OKAY        2'h0
`define RQC_RESP_SLVERR      2'h2
`define RQC_RESP_DECERR      2'h3
`endif

// >>> verilog/rqc_pkg.sv
// types of the receive queue command block
package rqc_pkg;
  typedef enum logic [1:0] {
    RQC_REL_IDLE = 2'b00,
    RQC_REL_BUSY = 2'b01
  } rqc_rel_e;
  typedef logic [15:0] rqc_word_t;
endpackage

// >>> verif/rqc_props.sv
// assertions on the receive queue command block ports
`timescale 1ns/1ps
`include "rqc_defines.svh"
module rqc_props (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // write channels
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  // queue side
  input wire logic        duration_exceeded,
  input wire logic        byte_count_exceeded,
  input wire logic        frame_count_exceeded,
  input wire logic        release_req,
  input wire logic        release_done,
  input wire logic        header_align_offset_en,
  input wire logic        auto_dequeue_en,
  input wire logic        dma_window_open,
  input wire logic        rx_irq_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire logic cmd_go = wr_go && s_axi_awaddr == `RQC_CMD_ADDR;
  // only the mapped non-command places are refused
  wire logic reg_go = wr_go && s_axi_awaddr inside {`RQC_STAT_ADDR, `RQC_MASK_ADDR, `RQC_THR_ADDR, `RQC_ISR_ADDR};
  a_window_blocks: assert property (dma_window_open && reg_go |=> s_axi_bresp == `RQC_RESP_SLVERR)
    else $error("write not refused while window open");
  a_window_follows: assert property (cmd_go && s_axi_wstrb[0] |=> dma_window_open == $past(s_axi_wdata[3]))
    else $error("window does not follow bit 3");
  a_align_follows: assert property (cmd_go && s_axi_wstrb[1] |=> header_align_offset_en == $past(s_axi_wdata[9]))
    else $error("align enable does not follow bit 9");
  a_dequeue_follows: assert property (cmd_go && s_axi_wstrb[0] |=> auto_dequeue_en == $past(s_axi_wdata[4]))
    else $error("dequeue enable does not follow bit 4");
  a_release_start: assert property (cmd_go && s_axi_wstrb[0] && s_axi_wdata[0] && !release_req |=> release_req)
    else $error("release not requested");
  a_release_hold: assert property (release_req && !release_done |=> release_req)
    else $error("release dropped before freed");
  a_release_clear: assert property (release_req && release_done |=> !release_req)
    else $error("release not cleared after freed");
  a_irq_quiet: assert property (!(duration_exceeded || byte_count_exceeded || frame_count_exceeded) |-> !rx_irq_req)
    else $error("rx interrupt without condition");
  c_release: cover property (release_req && release_done);
  c_blocked: cover property (dma_window_open && reg_go);
  c_irq: cover property (rx_irq_req);
endmodule

// >>> verif/rqc_queue_model.sv
// queue memory stand-in answering frame release requests
`timescale 1ns/1ps
module rqc_queue_model (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // release handshake
  input wire logic       release_req,
  input wire logic [3:0] lat,
  output logic           release_done
);
  logic [3:0] wait_q;
  // freeing takes lat cycles; done never shown unless asked
  assign release_done = release_req && wait_q == lat;
  always_ff @(posedge aclk) begin
    if (!aresetn || !release_req) wait_q <= 4'h0;
    else if (!release_done) wait_q <= wait_q + 4'h1;
  end
endmodule

// >>> verif/tb_rx_queue_command_control.sv
// testbench for the receive queue command block
`timescale 1ns/1ps
`include "rqc_defines.svh"
module tb_rx_queue_command_control;
  localparam logic [11:0] CMD = `RQC_CMD_ADDR;
  localparam logic [11:0] STA = `RQC_STAT_ADDR;
  localparam logic [1:0]  OK = `RQC_RESP_OKAY;
  localparam logic [1:0]  SLV = `RQC_RESP_SLVERR;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic duration_exceeded = 1'b0, byte_count_exceeded = 1'b0, frame_count_exceeded = 1'b0, s_axi_rvalid;
  logic release_req, release_done, header_align_offset_en, auto_dequeue_en, dma_window_open, rx_irq_req, irq;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb = 4'h0, lat = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  int          num_errors = 0, num_checks = 0, n;
  always #5 aclk = ~aclk;
  rqc_receive_queue_command i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .duration_exceeded,
    .byte_count_exceeded, .frame_count_exceeded, .release_req, .release_done, .header_align_offset_en,
    .auto_dequeue_en, .dma_window_open, .rx_irq_req, .irq);
  rqc_queue_model i_mem (.aclk, .aresetn, .release_req, .lat, .release_done);
  task automatic close_out;
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: data %h not %h", $time, g, e);
    end
  endtask
  task automatic chk_rsp(input logic [1:0] g, input logic [1:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: response %h not %h", $time, g, e);
    end
  endtask
  // flags are compared mid-cycle, where they have settled
  task automatic chk_bit(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: flag %b not %b", $time, g, e);
    end
  endtask
  task automatic hang;
    num_errors++;
    $display("mismatch at %0t: no answer", $time);
    close_out();
  endtask
  // ready is looked at in the low half so the edge never races the design
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tb;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tb = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tb) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask
  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    logic [1:0] r;
    wr(a, d, s, r);
    chk_rsp(r, e);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
    chk_rsp(r, er);
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(CMD, 32'h0, OK);
    wr_chk(CMD, 32'he2f0, 4'h3, OK);
    rd_chk(CMD, 32'he2f0, OK);
    @(negedge aclk);
    chk_bit(header_align_offset_en && auto_dequeue_en, 1'b1);
    chk_bit(rx_irq_req, 1'b0);
    @(posedge aclk);
    {duration_exceeded, byte_count_exceeded, frame_count_exceeded} <= 3'b111;
    rd_chk(`RQC_THR_ADDR, 32'h7, OK);
    // one enable at a time: only its cause may be latched
    for (int i = 0; i < 3; i++) begin
      wr_chk(CMD, 32'h80 >> i, 4'h3, OK);
      rd_chk(CMD, (32'h80 >> i) | (i == 0 ? 32'h0 : 32'h2000 >> i), OK);
      rd_chk(`RQC_ISR_ADDR, 32'h2000, OK);
      wr_chk(`RQC_ISR_ADDR, 32'h2000, 4'h2, OK);
      rd_chk(CMD, (32'h80 >> i) | (32'h1000 >> i), OK);
      @(negedge aclk);
      chk_bit(rx_irq_req, 1'b1);
    end
    wr_chk(CMD, 32'h0, 4'h3, OK);
    @(negedge aclk);
    chk_bit(rx_irq_req, 1'b0);
    @(posedge aclk);
    {duration_exceeded, byte_count_exceeded, frame_count_exceeded} <= 3'b000;
    rd_chk(STA, 32'h2, OK);
    wr_chk(STA, 32'h7, 4'h1, OK);
    wr_chk(CMD, 32'h8, 4'h1, OK);
    wr_chk(`RQC_MASK_ADDR, 32'h4, 4'h1, SLV);
    rd_chk(`RQC_THR_ADDR, 32'h0, SLV);
    rd_chk(CMD, 32'h400, OK);
    wr_chk(CMD, 32'h0, 4'h1, OK);
    rd_chk(STA, 32'h4, OK);
    @(negedge aclk);
    chk_bit(irq, 1'b0);
    wr_chk(`RQC_MASK_ADDR, 32'h4, 4'h1, OK);
    @(negedge aclk);
    chk_bit(irq, 1'b1);
    wr_chk(STA, 32'h4, 4'h1, OK);
    @(negedge aclk);
    chk_bit(irq, 1'b0);
    // release answered promptly, then slowly
    for (int j = 0; j < 2; j++) begin
      @(posedge aclk);
      lat <= 4'(j * 6);
      wr_chk(CMD, 32'h1, 4'h1, OK);
      for (n = 0; n < 20; n++) begin
        rd(CMD, rdat, rsp);
        if (rdat[0] === 1'b0) break;
      end
      chk(rdat, 32'h400);
      rd_chk(STA, 32'h1, OK);
      wr_chk(STA, 32'h1, 4'h1, OK);
    end
    wr_chk(12'h100, 32'h1, 4'hf, `RQC_RESP_DECERR);
    rd_chk(12'h100, 32'h0, `RQC_RESP_DECERR);
    close_out();
  end
endmodule
bind rqc_receive_queue_command rqc_props i_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .duration_exceeded, .byte_count_exceeded,
  .frame_count_exceeded, .release_req, .release_done, .header_align_offset_en, .auto_dequeue_en, .dma_window_open,
  .rx_irq_req);
